// file: design/esil_top.sv
// Behaviour
// - while the ready function is on, the output stage stays active without a run command.
// - with the ready function off, a run command first passes through the start delay.
// - an open hard-stop contact gates the output stage combinationally, not via software.
// - with the stop feature on, terminals 3 and 4 lose their old functions.
// - the hard-stop input is normally closed; low means stop and latches trip code 37.
// - a missing, broken or wrong-level hard-stop line also trips.
// - fault clear on terminal 4 is normally open and releases the latched trip.
// - only terminal 4 releases the trip; no bus write can.
// - with the switch on, slot 3 is hard stop, slot 4 fault clear, and writes are refused.
// - with the switch on, slot 5 becomes unassigned until software assigns it.
// - switching from on to off unassigns slot 3 and keeps slot 4 as plain fault clear.
// - the hard-stop function uses code 64; off (low) means stop requested.
// - two physical outputs, each takes any output function.
// - the relay output carries the alarm function after reset.
module esil_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [4:0]  term_in,
    input  wire logic        hard_stop_enable_switch,
    input  wire logic        switch_was_on,
    output logic             switch_state,
    output logic             stage_enable,
    output logic             xstr_out,
    output logic             relay_out,
    output logic      [7:0]  hard_stop_trip_code,
    output logic             fault_reset,
    output logic      [1:0]  speed_select,
    output logic             irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [esil_pkg::NUM_SLOTS-1:0][esil_pkg::FUNC_W-1:0] slot;
        logic [7:0]                 out_xstr;
        logic [7:0]                 out_relay;
        logic [esil_pkg::ST_W-1:0]  status;
        logic [esil_pkg::ST_W-1:0]  mask;
        logic                       sw_on;
        logic                       sampled;
        esil_pkg::esil_run_t        run;
        logic [esil_pkg::CNT_W-1:0] cnt;
        logic                       stage;
        logic                       ready;
        logic                       ap_valid;
        logic                       ap_write;
        logic [7:0]                 ap_addr;
        logic [31:0]                rdata;
        logic                       xstr;
        logic                       relay;
        logic                       fclr;
        logic [1:0]                 speed;
    } esil_state_t;

    localparam esil_state_t RESET_STATE = '{
        slot:      {esil_pkg::FN_FAULT_CLEAR, esil_pkg::FN_SPEED_BIT1,
                    esil_pkg::FN_SPEED_BIT0, esil_pkg::FN_REVERSE_RUN,
                    esil_pkg::FN_FORWARD_RUN},
        out_xstr:  esil_pkg::OUT_RUN,
        out_relay: esil_pkg::OUT_ALARM,
        run:       esil_pkg::RUN_IDLE,
        default:   '0
    };

    esil_state_t q;
    esil_state_t d;

    esil_trip_if tif ();

    esil_trip u_trip (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .tif  (tif.lat)
    );

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic func_active(
        input logic [esil_pkg::NUM_SLOTS-1:0][esil_pkg::FUNC_W-1:0] slots,
        input logic [esil_pkg::NUM_SLOTS-1:0]                       pins,
        input logic [7:0]                                           code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < esil_pkg::NUM_SLOTS; i++) begin
            if (slots[i] == code && pins[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : func_active

    function automatic logic out_value(
        input logic [7:0] code,
        input logic       running,
        input logic       tripped
    );
        logic v;
        v = 1'b0;
        if (code == esil_pkg::OUT_RUN) begin
            v = running;
        end else if (code == esil_pkg::OUT_ALARM) begin
            v = tripped;
        end
        return v;
    endfunction : out_value

    // ------------------------------------------------------------
    // per-slot lock and active pins
    // ------------------------------------------------------------
    logic [esil_pkg::NUM_SLOTS-1:0] slot_lock;
    logic [esil_pkg::NUM_SLOTS-1:0] slot_pin;

    for (genvar g = 0; g < esil_pkg::NUM_SLOTS; g++) begin : g_slot
        // claimed terminals never feed the general decode
        assign slot_lock[g] = q.sw_on && (g == esil_pkg::SLOT_HS || g == esil_pkg::SLOT_FC);
        assign slot_pin[g]  = term_in[g] && !slot_lock[g];
    end

    // ------------------------------------------------------------
    // hardware stop path
    // ------------------------------------------------------------
    logic hs_open;
    logic run_cmd;
    logic ready_fn;
    logic ap_take;
    logic [esil_pkg::ST_W-1:0] st_clr;
    logic [esil_pkg::ST_W-1:0] st_set;

    // low level on terminal 3 means stop; code 64 owns that slot
    assign hs_open = q.sw_on && q.slot[esil_pkg::SLOT_HS] == esil_pkg::FN_HARD_STOP
                     && !term_in[esil_pkg::SLOT_HS];
    assign tif.hard_stop_open = hs_open;
    // release needs the contact closed again, else the latch re-arms
    assign tif.clear_req = q.sw_on && term_in[esil_pkg::SLOT_FC] && !hs_open;

    assign run_cmd  = func_active(q.slot, slot_pin, esil_pkg::FN_FORWARD_RUN)
                    | func_active(q.slot, slot_pin, esil_pkg::FN_REVERSE_RUN);
    assign ready_fn = func_active(q.slot, slot_pin, esil_pkg::FN_READY);
    assign ap_take  = hsel && htrans[1] && hready;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d        = q;
        st_clr   = '0;
        st_set   = '0;
        d.ready  = ready_fn;

        // one-shot capture of the switch after reset
        if (!q.sampled) begin
            d.sampled = 1'b1;
            d.sw_on   = hard_stop_enable_switch;
            if (hard_stop_enable_switch) begin
                d.slot[esil_pkg::SLOT_HS]    = esil_pkg::FN_HARD_STOP;
                d.slot[esil_pkg::SLOT_FC]    = esil_pkg::FN_FAULT_CLEAR;
                d.slot[esil_pkg::SLOT_SPARE] = esil_pkg::FN_NONE;
            end else if (switch_was_on) begin
                d.slot[esil_pkg::SLOT_HS] = esil_pkg::FN_NONE;
                d.slot[esil_pkg::SLOT_FC] = esil_pkg::FN_FAULT_CLEAR;
            end
        end

        // run sequencing
        unique case (q.run)
            esil_pkg::RUN_IDLE: begin
                if (run_cmd && !tif.trip) begin
                    if (ready_fn) begin
                        d.run = esil_pkg::RUN_RUNNING;
                    end else begin
                        d.run = esil_pkg::RUN_STARTING;
                        d.cnt = '0;
                    end
                end
            end
            esil_pkg::RUN_STARTING: begin
                if (!run_cmd || tif.trip) begin
                    d.run = esil_pkg::RUN_IDLE;
                end else if (q.cnt == esil_pkg::START_LAST) begin
                    d.run = esil_pkg::RUN_RUNNING;
                end else begin
                    d.cnt = q.cnt + 8'h01;
                end
            end
            esil_pkg::RUN_RUNNING: begin
                if (!run_cmd || tif.trip) begin
                    d.run = esil_pkg::RUN_IDLE;
                end
            end
        endcase

        d.stage = (ready_fn || d.run == esil_pkg::RUN_RUNNING) && !tif.trip;

        // output function routing
        d.xstr  = out_value(q.out_xstr,  q.run == esil_pkg::RUN_RUNNING, tif.trip);
        d.relay = out_value(q.out_relay, q.run == esil_pkg::RUN_RUNNING, tif.trip);
        d.fclr  = func_active(q.slot, slot_pin, esil_pkg::FN_FAULT_CLEAR)
                | (q.sw_on && term_in[esil_pkg::SLOT_FC]);
        d.speed = {func_active(q.slot, slot_pin, esil_pkg::FN_SPEED_BIT1),
                   func_active(q.slot, slot_pin, esil_pkg::FN_SPEED_BIT0)};

        // bus address phase, read data sampled here
        d.ap_valid = ap_take;
        if (ap_take) begin
            d.ap_write = hwrite;
            d.ap_addr  = haddr[7:0];
            d.rdata    = '0;
            if (haddr[7:0] <= esil_pkg::OFF_SLOT5 && haddr[1:0] == 2'b00) begin
                d.rdata[7:0] = q.slot[haddr[4:2]];
            end else begin
                unique case (haddr[7:0])
                    esil_pkg::OFF_OUT_XSTR:  d.rdata[7:0] = q.out_xstr;
                    esil_pkg::OFF_OUT_RELAY: d.rdata[7:0] = q.out_relay;
                    esil_pkg::OFF_STATUS:    d.rdata[esil_pkg::ST_W-1:0] = q.status;
                    esil_pkg::OFF_MASK:      d.rdata[esil_pkg::ST_W-1:0] = q.mask;
                    esil_pkg::OFF_STATE: begin
                        d.rdata[esil_pkg::SR_TRIP]    = tif.trip;
                        d.rdata[esil_pkg::SR_SW_ON]   = q.sw_on;
                        d.rdata[esil_pkg::SR_STAGE]   = stage_enable;
                        d.rdata[esil_pkg::SR_READY]   = q.ready;
                        d.rdata[esil_pkg::SR_RUNNING] = q.run == esil_pkg::RUN_RUNNING;
                        d.rdata[esil_pkg::SR_CODE_LO +: 8] = hard_stop_trip_code;
                    end
                    default: d.rdata = '0;
                endcase
            end
        end

        // bus data phase writes
        if (q.ap_valid && q.ap_write) begin
            if (q.ap_addr <= esil_pkg::OFF_SLOT5 && q.ap_addr[1:0] == 2'b00) begin
                // claimed slots ignore writes while the switch is on
                if (!slot_lock[q.ap_addr[4:2]]) begin
                    d.slot[q.ap_addr[4:2]] = hwdata[7:0];
                end
            end else begin
                unique case (q.ap_addr)
                    esil_pkg::OFF_OUT_XSTR:  d.out_xstr  = hwdata[7:0];
                    esil_pkg::OFF_OUT_RELAY: d.out_relay = hwdata[7:0];
                    esil_pkg::OFF_STATUS:    st_clr      = hwdata[esil_pkg::ST_W-1:0];
                    esil_pkg::OFF_MASK:      d.mask      = hwdata[esil_pkg::ST_W-1:0];
                    default: ;
                endcase
            end
        end

        // set wins over a same-cycle clear
        st_set[esil_pkg::ST_TRIP]    = tif.set_pulse;
        st_set[esil_pkg::ST_RELEASE] = tif.release_pulse;
        d.status = (q.status & ~st_clr) | st_set;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= RESET_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // combinational gate so a stop acts even if the register is stale
    assign stage_enable        = q.stage && !hs_open && !tif.trip;
    assign hard_stop_trip_code = tif.trip ? esil_pkg::TRIP_CODE_HS : 8'h00;
    assign switch_state        = q.sw_on;
    assign xstr_out            = q.xstr;
    assign relay_out           = q.relay;
    assign fault_reset         = q.fclr;
    assign speed_select        = q.speed;
    assign irq                 = |(q.status & q.mask);
    assign hrdata              = q.rdata;
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
endmodule : esil_top

// file: design/esil_pkg.sv
package esil_pkg;

    // ------------------------------------------------------------
    // sizes and slot positions
    // ------------------------------------------------------------
    localparam int          NUM_SLOTS  = 5;
    localparam int          FUNC_W     = 8;
    localparam int          SLOT_FWD   = 0;
    localparam int          SLOT_REV   = 1;
    localparam int          SLOT_HS    = 2;
    localparam int          SLOT_FC    = 3;
    localparam int          SLOT_SPARE = 4;

    // ------------------------------------------------------------
    // input function codes
    // ------------------------------------------------------------
    localparam logic [7:0]  FN_FORWARD_RUN  = 8'h00;
    localparam logic [7:0]  FN_REVERSE_RUN  = 8'h01;
    localparam logic [7:0]  FN_SPEED_BIT0   = 8'h02;
    localparam logic [7:0]  FN_SPEED_BIT1   = 8'h03;
    localparam logic [7:0]  FN_FAULT_CLEAR  = 8'h12;
    localparam logic [7:0]  FN_THERMISTOR   = 8'h13;
    localparam logic [7:0]  FN_READY        = 8'h34;
    localparam logic [7:0]  FN_HARD_STOP    = 8'h40;
    localparam logic [7:0]  FN_NONE         = 8'hFF;

    // ------------------------------------------------------------
    // output function codes and trip code
    // ------------------------------------------------------------
    localparam logic [7:0]  OUT_RUN         = 8'h00;
    localparam logic [7:0]  OUT_ALARM       = 8'h05;
    localparam logic [7:0]  TRIP_CODE_HS    = 8'h25;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_SLOT1       = 8'h00;
    localparam logic [7:0]  OFF_SLOT5       = 8'h10;
    localparam logic [7:0]  OFF_OUT_XSTR    = 8'h14;
    localparam logic [7:0]  OFF_OUT_RELAY   = 8'h18;
    localparam logic [7:0]  OFF_STATUS      = 8'h1C;
    localparam logic [7:0]  OFF_MASK        = 8'h20;
    localparam logic [7:0]  OFF_STATE       = 8'h24;

    // status / mask bits
    localparam int          ST_TRIP         = 0;
    localparam int          ST_RELEASE      = 1;
    localparam int          ST_W            = 2;

    // state register fields
    localparam int          SR_TRIP         = 0;
    localparam int          SR_SW_ON        = 1;
    localparam int          SR_STAGE        = 2;
    localparam int          SR_READY        = 3;
    localparam int          SR_RUNNING      = 4;
    localparam int          SR_CODE_LO      = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          START_TIME_NS   = 1000;
    localparam int          START_CYCLES    = (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 8;
    localparam logic [7:0]  START_LAST      = 8'(START_CYCLES - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_STARTING,
        RUN_RUNNING
    } esil_run_t;

    typedef struct packed {
        logic trip;
        logic set_p;
        logic rel_p;
    } esil_trip_state_t;

endpackage : esil_pkg

// file: design/esil_trip_if.sv
interface esil_trip_if;
    logic hard_stop_open;
    logic clear_req;
    logic trip;
    logic set_pulse;
    logic release_pulse;

    modport ctl (output hard_stop_open, output clear_req,
                 input trip, input set_pulse, input release_pulse);
    modport lat (input hard_stop_open, input clear_req,
                 output trip, output set_pulse, output release_pulse);
endinterface : esil_trip_if

// file: design/esil_trip.sv
module esil_trip (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    esil_trip_if.lat tif
);
    esil_pkg::esil_trip_state_t q;
    esil_pkg::esil_trip_state_t d;

    always_comb begin
        d       = q;
        d.set_p = 1'b0;
        d.rel_p = 1'b0;
        if (tif.hard_stop_open) begin
            // open contact holds or re-latches the trip
            d.trip  = 1'b1;
            d.set_p = ~q.trip;
        end else if (q.trip && tif.clear_req) begin
            // only the terminal clear releases; bus has no path here
            d.trip  = 1'b0;
            d.rel_p = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign tif.trip          = q.trip;
    assign tif.set_pulse     = q.set_p;
    assign tif.release_pulse = q.rel_p;
endmodule : esil_trip

// file: sim/esil_contacts.sv
module esil_contacts (
    input  wire logic       closed_want,
    input  wire logic [4:0] want_all,
    input  wire logic       broken,
    output logic      [4:0] term_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // contacts
    // ----
    // a cut hard-stop wire floats open, so it reads as a stop request
    assign term_in = closed_want ? (want_all & ~{2'h0, broken, 2'h0}) : 5'h00;
endmodule : esil_contacts

// file: sim/esil_top_asserts.sv
module esil_top_asserts (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       ce,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [4:0] term_in,
    input wire logic       switch_state,
    input wire logic       stage_enable,
    input wire logic       relay_out,
    input wire logic [7:0] hard_stop_trip_code,
    input wire logic       fault_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----
    // stop path, trip latch, fault clear and bus answer
    // ----
    stop_gates_stage_a: assert property (switch_state && !term_in[2] |-> !stage_enable)
        else $error("stage active while hard stop open");
    trip_sets_a: assert property (ce && switch_state && !term_in[2] |=> hard_stop_trip_code == 8'h25)
        else $error("no trip code after stop request");
    trip_holds_a: assert property (ce && hard_stop_trip_code == 8'h25 && !(term_in[3] && term_in[2])
        |=> hard_stop_trip_code == 8'h25)
        else $error("trip released without clear");
    trip_release_a: assert property (ce && hard_stop_trip_code == 8'h25 && term_in[3] && term_in[2]
        |=> hard_stop_trip_code == 8'h00)
        else $error("trip not released by clear");
    code_values_a: assert property (hard_stop_trip_code == 8'h00 || hard_stop_trip_code == 8'h25)
        else $error("trip code out of range");
    relay_alarm_a: assert property ($rose(hard_stop_trip_code == 8'h25) |=> relay_out)
        else $error("relay alarm missing after trip");
    clear_follows_a: assert property (ce && switch_state |=> fault_reset == $past(term_in[3]))
        else $error("fault clear not on terminal 4");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
endmodule : esil_top_asserts

bind esil_top esil_top_asserts chk_u (
    .clk(clk), .rstn(rstn), .ce(ce), .hreadyout(hreadyout), .hresp(hresp),
    .term_in(term_in), .switch_state(switch_state), .stage_enable(stage_enable),
    .relay_out(relay_out), .hard_stop_trip_code(hard_stop_trip_code), .fault_reset(fault_reset)
);

// file: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] a; logic w; logic [31:0] d; logic [31:0] e;} esil_row_t;
    logic        clk, rstn, hsel, hwrite, hreadyout, hresp, broken, sw, was_on, ce;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, speed_select;
    logic [4:0]  want, term_in;
    logic        switch_state, stage_enable, xstr_out, relay_out, fault_reset, irq;
    logic [7:0]  code;
    int          fails, total_checks;
    esil_row_t   rows [14] = '{
        '{32'h00, 0, 0, 32'h00}, '{32'h04, 0, 0, 32'h01},
        '{32'h08, 0, 0, 32'h40}, '{32'h0C, 0, 0, 32'h12},
        '{32'h10, 0, 0, 32'hFF}, '{32'h18, 0, 0, 32'h05},
        '{32'h14, 0, 0, 32'h00}, '{32'h08, 1, 32'h02, 32'h40},
        '{32'h0C, 1, 32'h03, 32'h12}, '{32'h10, 1, 32'h13, 32'h13},
        '{32'h30, 1, 32'h5A, 32'h00}, '{32'h24, 1, 32'hFF, 32'h02},
        '{32'h20, 1, 32'h03, 32'h03}, '{32'h1C, 0, 0, 32'h00}
    };

    esil_contacts sw_u (.closed_want(1'b1), .want_all(want), .broken(broken), .term_in(term_in));
    esil_top dut_u (
        .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .term_in(term_in),
        .hard_stop_enable_switch(sw), .switch_was_on(was_on), .switch_state(switch_state),
        .stage_enable(stage_enable), .xstr_out(xstr_out), .relay_out(relay_out),
        .hard_stop_trip_code(code), .fault_reset(fault_reset),
        .speed_select(speed_select), .irq(irq)
    );
    // ----
    // helpers
    // ----
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // generous: the run needs about 330 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
    // ----
    // sequence
    // ----
    initial begin
        rstn = 1'b0; hsel = 1'b0; haddr = 0; htrans = 2'h0; hwrite = 1'b0; hwdata = 0;
        want = 5'h04; broken = 1'b0; sw = 1'b1; was_on = 1'b0; fails = 0; total_checks = 0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        chk("stage_rst", 0, stage_enable);
        chk("irq_rst", 0, irq);
        chk("code_rst", 0, code);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
            bus(rows[i].a, 1'b0, 0);
            chk($sformatf("reg_%h", rows[i].a), rows[i].e, rd);
        end
        @(posedge clk);
        broken <= 1'b1;
        #1 chk("stage_stop", 0, stage_enable);
        repeat (3) @(posedge clk);
        #1 chk("trip_code", 32'h25, code);
        chk("relay_alarm", 1, relay_out);
        chk("irq_trip", 1, irq);
        bus(32'h1C, 1'b0, 0);
        chk("status_set", 32'h01, rd);
        want <= 5'h0C;
        repeat (4) @(posedge clk);
        #1 chk("clear_while_open", 32'h25, code);
        want <= 5'h04;
        bus(32'h1C, 1'b1, 32'h01);
        bus(32'h24, 1'b0, 0);
        chk("state_tripped", 32'h2503, rd);
        chk("irq_w1c", 0, irq);
        @(posedge clk);
        broken <= 1'b0;
        want <= 5'h0C;
        repeat (5) @(posedge clk);
        #1 chk("released", 0, code);
        chk("irq_release", 1, irq);
        bus(32'h1C, 1'b1, 32'h03);
        @(posedge clk);
        want <= 5'h04;
        #1 chk("irq_cleared", 0, irq);
        bus(32'h10, 1'b1, 32'h34);
        want <= 5'h14;
        repeat (4) @(posedge clk);
        #1 chk("ready_stage", 1, stage_enable);
        want <= 5'h04;
        repeat (5) @(posedge clk);
        want <= 5'h05;
        repeat (esil_pkg::START_CYCLES) @(posedge clk);
        #1 chk("start_delay", 0, stage_enable);
        @(posedge clk);
        #1 chk("run_stage", 1, stage_enable);
        @(posedge clk);
        #1 chk("xstr_run", 1, xstr_out);
        // open the contact while the stage is live: the gate must act before any edge
        @(posedge clk);
        broken <= 1'b1;
        #1 chk("stage_cut", 0, stage_enable);
        sw <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("switch_kept", 1, switch_state);
        rstn <= 1'b0;
        was_on <= 1'b1;
        want <= 5'h00;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        bus(32'h08, 1'b0, 0);
        chk("slot3_off", 32'hFF, rd);
        bus(32'h0C, 1'b0, 0);
        chk("slot4_off", 32'h12, rd);
        chk("no_trip_off", 0, code);
        bus(32'h00, 1'b1, 32'h03);
        want <= 5'h09;
        repeat (2) @(posedge clk);
        #1 chk("speed_bits", 32'h2, speed_select);
        chk("clear_plain", 1, fault_reset);
        // enable low must freeze the registered outputs
        @(posedge clk);
        ce <= 1'b0;
        want <= 5'h00;
        repeat (3) @(posedge clk);
        #1 chk("ce_hold", 32'h2, speed_select);
        give_verdict();
    end
endmodule : testbench
